// ==== hdl/fep_flash_ctrl.sv ====
// Flash array with block erase and per-unit protection
// Functional notes
// - Array holds 256 KB as 65536 words, split into 256 blocks of 1 KB.
// - Erase clears one 1 KB block only, leaving other blocks intact.
// - An erased block reads all ones in every bit.
// - Protection applies per 2 KB unit, two adjacent blocks sharing one setting.
// - Each unit is unprotected, read-only or execute-only.
// - Read-only units refuse erase and program; reads allowed.
// - Execute-only units refuse erase, program, data reads and debugger reads.
// - Permitted reads return data one clock cycle after the request.
`include "fep_consts.svh"
module fep_flash_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire fep_pkg::fep_rd_req_t rd_req_i,
  input  wire fep_pkg::fep_wr_req_t wr_req_i,
  input  wire logic [255:0]         prot_map_i,
  input  wire logic                 viol_clr_i,
  output logic                      rd_valid_o,
  output logic                      rd_denied_o,
  output logic [31:0]               rd_data_o,
  output logic                      busy_o,
  output logic                      wr_done_o,
  output logic                      viol_o
);
  import fep_pkg::*;

  // Storage, one 32-bit word per address
  // Contents survive reset; erase a block before trusting it
  logic [31:0] mem [0:`FEP_WORDS-1];
  fep_state_t  s_r;
  fep_state_t  s_nxt;
  logic        rd_allow;
  logic        wr_allow;
  logic        rd_take;
  logic        rd_refused;
  logic        wr_refused;
  logic        wr_idle;
  logic        erase_take;
  logic        prog_take;
  logic        erase_last;
  logic        mem_we;
  logic [15:0] mem_wa;
  logic [15:0] erase_wa;
  logic [31:0] mem_wd;
  logic [31:0] rd_word;
  logic [31:0] prog_word;

  // Reset image of the state: idle, no answer pending, flag clear
  localparam fep_state_t S_RST = '{
    st:      FEP_ST_IDLE,
    blk:     '0,
    woff:    '0,
    rd_ok:   '0,
    rd_deny: '0,
    rdata:   '0,
    viol:    '0,
    done:    '0
  };

  // Rights of the read port against its unit's code
  fep_prot_chk #(
    .UNIT_AW    (`FEP_UNIT_AW)
  ) i_fep_prot_chk_rd (
    .unit_i     (rd_req_i.addr[`FEP_UNIT_HI:`FEP_UNIT_LO]),
    .prot_map_i (prot_map_i),
    .fetch_i    (rd_req_i.fetch),
    .dbg_i      (rd_req_i.dbg),
    .rd_ok_o    (rd_allow),
    .wr_ok_o    ()
  );

  // Rights of the program and erase port
  // Fetch and debugger qualifiers do not apply to writes
  fep_prot_chk #(
    .UNIT_AW    (`FEP_UNIT_AW)
  ) i_fep_prot_chk_wr (
    .unit_i     (wr_req_i.addr[`FEP_UNIT_HI:`FEP_UNIT_LO]),
    .prot_map_i (prot_map_i),
    .fetch_i    (`FEP_TIE_LOW),
    .dbg_i      (`FEP_TIE_LOW),
    .rd_ok_o    (),
    .wr_ok_o    (wr_allow)
  );

  // Qualified requests; any program or erase arriving mid-erase is dropped silently
  always_comb begin
    wr_idle    = (s_r.st == FEP_ST_IDLE);
    erase_take = wr_idle && wr_req_i.erase && wr_allow;
    prog_take  = wr_idle && wr_req_i.prog && !wr_req_i.erase && wr_allow; // Erase wins
  end

  // Erase walk position and end
  always_comb begin
    erase_wa   = {s_r.blk, s_r.woff};
    erase_last = (s_r.woff == `FEP_WOFF_LAST);
  end

  // Read outcome and refusals that raise the violation flag
  always_comb begin
    rd_take    = rd_req_i.vld && rd_allow;
    rd_refused = rd_req_i.vld && !rd_allow;
    wr_refused = wr_idle && (wr_req_i.erase || wr_req_i.prog) && !wr_allow;
  end

  // Array words for the read port and the program merge
  always_comb begin
    rd_word   = mem[rd_req_i.addr];
    prog_word = mem[wr_req_i.addr] & wr_req_i.data; // Program only clears bits
  end

  // Reads during an erase see a block that is only partly set
  // Next state: read answer, erase walk, program and violation flag
  always_comb begin
    s_nxt         = s_r;
    // Read answer, one cycle after the request
    s_nxt.rd_ok   = rd_take;
    s_nxt.rd_deny = rd_refused;
    s_nxt.rdata   = `FEP_ZERO32;
    s_nxt.done    = 1'b0;
    mem_we        = 1'b0;
    mem_wa        = wr_req_i.addr;
    mem_wd        = prog_word;
    if (rd_take) begin
      s_nxt.rdata = rd_word;
    end
    // Erase walk and program
    unique case (s_r.st)
      FEP_ST_IDLE: begin
        if (erase_take) begin
          s_nxt.st   = FEP_ST_ERASE;
          s_nxt.blk  = wr_req_i.addr[`FEP_BLK_HI:`FEP_BLK_LO];
          s_nxt.woff = `FEP_WOFF_ZERO;
        end else if (prog_take) begin
          mem_we     = 1'b1;
          s_nxt.done = 1'b1;
        end
      end
      FEP_ST_ERASE: begin
        // One word per cycle, offset counting up from zero
        mem_we     = 1'b1;
        mem_wa     = erase_wa;
        mem_wd     = `FEP_ERASED;
        s_nxt.woff = s_r.woff + `FEP_WOFF_STEP;
        if (erase_last) begin
          s_nxt.st   = FEP_ST_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = FEP_ST_IDLE; // Recover from an illegal code
      end
    endcase
    // Violation flag: set wins over a clear in the same cycle
    if (viol_clr_i) begin
      s_nxt.viol = 1'b0;
    end
    if (rd_refused || wr_refused) begin
      s_nxt.viol = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array write port, no reset on storage
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Read answer outputs, straight from flip-flops
  assign rd_valid_o  = s_r.rd_ok;
  assign rd_denied_o = s_r.rd_deny;
  assign rd_data_o   = s_r.rdata;

  // Write side status
  assign busy_o      = (s_r.st == FEP_ST_ERASE);
  assign wr_done_o   = s_r.done;
  assign viol_o      = s_r.viol;
endmodule : fep_flash_ctrl

// Rights of one access against the two-bit code of its unit
module fep_prot_chk #(
  parameter int UNIT_AW = `FEP_UNIT_AW
) (
  input  wire logic [UNIT_AW-1:0]         unit_i,
  input  wire logic [`FEP_PROT_MAP_W-1:0] prot_map_i,
  input  wire logic                       fetch_i,
  input  wire logic                       dbg_i,
  output logic                            rd_ok_o,
  output logic                            wr_ok_o
);
  import fep_pkg::*;

  logic [UNIT_AW:0] bit_idx;
  fep_prot_t        prot;
  logic             is_fetch;

  // Both blocks of a pair share the unit index, so one field serves them
  always_comb begin
    bit_idx = {unit_i, `FEP_UNIT_BIT0};
    prot    = fep_prot_t'(prot_map_i[bit_idx +: `FEP_PROT_W]);
  end

  // Code three blocks writes and keeps reads open
  // A debugger access never counts as an instruction fetch
  always_comb begin
    is_fetch = fetch_i && !dbg_i;
    rd_ok_o  = (prot != FEP_PROT_XO) || is_fetch;
    wr_ok_o  = (prot == FEP_PROT_NONE);
  end
endmodule : fep_prot_chk

// ==== hdl/fep_consts.svh ====
// Constants for the flash erase and protection block
`ifndef FEP_CONSTS_SVH
`define FEP_CONSTS_SVH
`define FEP_WORDS      65536
`define FEP_AW         16
`define FEP_BLK_AW     8
`define FEP_BLK_WORDS  256
`define FEP_WOFF_AW    8
`define FEP_UNITS      128
`define FEP_UNIT_AW    7
`define FEP_ERASED     32'hFFFFFFFF
`define FEP_ZERO32     32'h00000000
`define FEP_WOFF_LAST  8'hFF
`define FEP_WOFF_ZERO  8'h00
`define FEP_WOFF_STEP  8'h01
`define FEP_UNIT_HI    15
`define FEP_UNIT_LO    9
`define FEP_BLK_HI     15
`define FEP_BLK_LO     8
`define FEP_PROT_W     2
`define FEP_PROT_MAP_W 256
`define FEP_UNIT_BIT0  1'b0
`define FEP_TIE_LOW    1'b0
`endif

// ==== hdl/fep_pkg.sv ====
// Types for the flash erase and protection block
package fep_pkg;
  typedef enum logic [1:0] {
    FEP_PROT_NONE = 2'h0,
    FEP_PROT_RO   = 2'h1,
    FEP_PROT_XO   = 2'h2
  } fep_prot_t;

  typedef enum logic [1:0] {
    FEP_ST_IDLE  = 2'h1,
    FEP_ST_ERASE = 2'h2
  } fep_st_t;

  // Read request from core or debugger
  typedef struct packed {
    logic        vld;
    logic        fetch;
    logic        dbg;
    logic [15:0] addr;
  } fep_rd_req_t;

  // Program or erase request
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic [15:0] addr;
    logic [31:0] data;
  } fep_wr_req_t;

  typedef struct packed {
    fep_st_t     st;
    logic [7:0]  blk;
    logic [7:0]  woff;
    logic        rd_ok;
    logic        rd_deny;
    logic [31:0] rdata;
    logic        viol;
    logic        done;
  } fep_state_t;
endpackage : fep_pkg

// ==== bench/fep_chk.sv ====
// Port checker for the flash controller
module fep_chk import fep_pkg::*; (
  input wire logic         clk_i,
  input wire logic         rst_b_i,
  input wire logic         viol_clr_i,
  input wire fep_rd_req_t  rd_req_i,
  input wire fep_wr_req_t  wr_req_i,
  input wire logic [255:0] prot_map_i,
  input wire logic         rd_valid_o,
  input wire logic         rd_denied_o,
  input wire logic         busy_o,
  input wire logic         wr_done_o,
  input wire logic         viol_o,
  input wire logic [31:0]  rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wp;
  // Protection code of the unit a write targets
  assign wp = prot_map_i[{wr_req_i.addr[15:9], 1'b0} +: 2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_start; wr_req_i.erase && !busy_o && wp == 2'h0; endsequence
  property p_ans; rd_req_i.vld |=> rd_valid_o != rd_denied_o; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_idl; !rd_req_i.vld |=> !rd_valid_o && !rd_denied_o; endproperty
  a_idl: assert property (p_idl) else $error("spurious read answer");
  property p_zer; rd_denied_o |-> rd_data_o == 32'h0; endproperty
  a_zer: assert property (p_zer) else $error("denied read leaks data");
  property p_vio; rd_denied_o |-> viol_o; endproperty
  a_vio: assert property (p_vio) else $error("no flag on denial");
  property p_ers; s_start |=> busy_o [*8]; endproperty
  a_ers: assert property (p_ers) else $error("erase not busy");
  property p_end; $fell(busy_o) |-> wr_done_o; endproperty
  a_end: assert property (p_end) else $error("erase end without done");
  property p_ro; wr_req_i.erase && !busy_o && wp != 2'h0 |=> !busy_o && viol_o; endproperty
  a_ro: assert property (p_ro) else $error("protected erase ran");
  property p_prg; wr_req_i.prog && !wr_req_i.erase && !busy_o && wp == 2'h0 |=> wr_done_o;
  endproperty
  a_prg: assert property (p_prg) else $error("program not done");
endmodule : fep_chk

// ==== bench/fep_core_mdl.sv ====
// Model of the core and debugger issuing flash requests
module fep_core_mdl import fep_pkg::*; (
  input  wire logic  clk_i,
  output fep_rd_req_t rd_req_o,
  output fep_wr_req_t wr_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin rd_req_o = '0; wr_req_o = '0; end
  // One-cycle request, then lines scrambled
  task rd(input logic [15:0] a, input logic f, d);
    @(posedge clk_i) #1 rd_req_o = {1'b1, f, d, a};
    @(posedge clk_i) #1 rd_req_o = {1'b0, f, d, ~a};
  endtask : rd
  task wr(input logic p, e, input logic [15:0] a, input logic [31:0] v);
    @(posedge clk_i) #1 wr_req_o = {p, e, a, v};
    @(posedge clk_i) #1 wr_req_o = {2'b0, ~a, ~v};
  endtask : wr
endmodule : fep_core_mdl

// ==== bench/fep_flash_ctrl_tb.sv ====
// Self-checking bench for the flash controller
module fep_flash_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fep_pkg::*;
  logic clk_i = 0, rst_b_i = 0, viol_clr_i = 0, rd_valid_o, rd_denied_o, busy_o, wr_done_o, viol_o;
  logic [255:0] prot_map_i = '0;
  logic [31:0] rd_data_o;
  fep_rd_req_t rd_req_i;
  fep_wr_req_t wr_req_i;
  int err_count = 0, check_count = 0;
  always #2.5 clk_i = ~clk_i;
  fep_flash_ctrl i_fep_flash_ctrl (.clk_i, .rst_b_i, .rd_req_i, .wr_req_i, .prot_map_i,
    .viol_clr_i, .rd_valid_o, .rd_denied_o, .rd_data_o, .busy_o, .wr_done_o, .viol_o);
  fep_core_mdl i_fep_core_mdl (.clk_i, .rd_req_o(rd_req_i), .wr_req_o(wr_req_i));
  task chk(string n, logic [31:0] e, g);
    check_count++;
    if (g !== e) begin err_count++; $display("wrong value %s exp %h got %h", n, e, g); end
  endtask : chk
  task rdc(logic [15:0] a, logic f, d, logic [31:0] e, logic ok);
    i_fep_core_mdl.rd(a, f, d);
    chk("valid", ok, rd_valid_o);
    chk("denied", !ok, rd_denied_o);
    chk("data", ok ? e : 32'h0, rd_data_o);
  endtask : rdc
  // Erase a block and wait for completion
  task ers(logic [15:0] a);
    i_fep_core_mdl.wr(1'b0, 1'b1, a, 32'h0);
    repeat (300) if (!wr_done_o) @(posedge clk_i) #1;
    chk("done", 1, wr_done_o);
  endtask : ers
  task t_erase();
    ers(16'h0400);
    i_fep_core_mdl.wr(1'b1, 1'b0, 16'h0403, 32'hA5A50F0F);
    ers(16'h0500);
    rdc(16'h0403, 0, 0, 32'hA5A50F0F, 1);
    rdc(16'h05FF, 0, 0, 32'hFFFFFFFF, 1);
  endtask : t_erase
  task t_prot();
    ers(16'h0600);
    prot_map_i[7:6] = 2'h1;
    i_fep_core_mdl.wr(1'b0, 1'b1, 16'h0700, 32'h0);
    chk("busy", 0, busy_o); chk("viol", 1, viol_o);
    rdc(16'h0610, 0, 1, 32'hFFFFFFFF, 1);
    prot_map_i[7:6] = 2'h2;
    i_fep_core_mdl.wr(1'b1, 1'b0, 16'h0610, 32'h0);
    rdc(16'h0610, 1, 0, 32'hFFFFFFFF, 1);
    rdc(16'h0610, 0, 0, 32'h0, 0);
    rdc(16'h0610, 1, 1, 32'h0, 0);
    viol_clr_i = 1;
    @(posedge clk_i) #1 viol_clr_i = 0;
    chk("viol", 0, viol_o);
  endtask : t_prot
  // Busy window, dropped program, program done, code three, set against clear
  task t_edge();
    prot_map_i[7:6] = 2'h0;
    i_fep_core_mdl.wr(1'b0, 1'b1, 16'h0600, 32'h0);
    chk("busy", 1, busy_o);
    i_fep_core_mdl.wr(1'b1, 1'b0, 16'h0612, 32'h0);
    chk("viol", 0, viol_o);
    repeat (300) if (!wr_done_o) @(posedge clk_i) #1;
    chk("done", 1, wr_done_o);
    rdc(16'h0612, 0, 0, 32'hFFFFFFFF, 1);
    i_fep_core_mdl.wr(1'b1, 1'b0, 16'h0611, 32'h12345678);
    chk("done", 1, wr_done_o);
    rdc(16'h0611, 0, 1, 32'h12345678, 1);
    prot_map_i[7:6] = 2'h3;
    rdc(16'h0611, 0, 1, 32'h12345678, 1);
    viol_clr_i = 1;
    i_fep_core_mdl.wr(1'b1, 1'b0, 16'h0611, 32'h0);
    viol_clr_i = 0;
    chk("viol", 1, viol_o);
    rdc(16'h0611, 0, 0, 32'h12345678, 1);
  endtask : t_edge
  task conclude();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin #20000; err_count++; conclude(); end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_b_i = 1;
    t_erase();
    t_prot();
    t_edge();
    conclude();
  end
endmodule : fep_flash_ctrl_tb
bind fep_flash_ctrl fep_chk i_fep_chk (.clk_i, .rst_b_i, .viol_clr_i, .rd_req_i, .wr_req_i,
  .prot_map_i, .rd_valid_o, .rd_denied_o, .busy_o, .wr_done_o, .viol_o, .rd_data_o);
